// ===== shared/adc_seq_pkg.sv
package adc_seq_pkg;

	// ----------------------------------------
	// Clock and link timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_GAP_NS = 160;
	localparam int CS_GAP_CYCLES = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_RATE_SPS = 50000;
	localparam int MAX_RATE_SPS = 1000000;
	localparam int FRAME_MIN_CYCLES = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
	localparam int FRAME_MAX_CYCLES = CLK_HZ / MIN_RATE_SPS;

	// ----------------------------------------
	// Conversion frame
	// ----------------------------------------
	localparam int NUM_INPUTS = 8;
	localparam int NUM_PAIRS = 4;
	localparam int RES_BITS = 12;
	localparam int CTRL_BITS = 8;
	localparam int FRAME_BITS = 16;
	localparam int TRACK_CYCLES = 3;
	localparam int HOLD_CONVERT_CYCLES = 13;
	localparam logic [3:0] HOLD_FALL_IDX = 4'h3;
	localparam logic [3:0] LAST_CTRL_RISE_IDX = 4'h7;
	localparam logic [3:0] LAST_EDGE_IDX = 4'hf;

	// ----------------------------------------
	// Control word fields
	// ----------------------------------------
	localparam int TOP_MSB = 7;
	localparam int TOP_LSB = 5;
	localparam int SEL_MSB = 5;
	localparam int SEL_LSB = 3;
	localparam int PAIR_MSB = 4;
	localparam int PAIR_LSB = 3;
	localparam int LOW_MSB = 2;
	localparam logic [2:0] DIFF_TOP_CODE = 3'h6;
	localparam logic [2:0] DIFF_LOW_CODE = 3'h1;
	localparam logic [1:0] SE_BAD_TOP_CODE = 2'h3;
	localparam logic [2:0] SE_BAD_LOW_CODE = 3'h1;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------
	// Controller registers
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_DATA = 4'hc;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_EMPTY_BIT = 4;
	localparam int STAT_FULL_BIT = 5;
	localparam int STAT_BUSY_BIT = 6;
	localparam logic RUN_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SHIFT = 2'b01,
		S_PUSH = 2'b10,
		S_GAP = 2'b11
	} host_state_t;

endpackage : adc_seq_pkg

// ===== shared/adc_link_if.sv
`timescale 1ns/10ps
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_line;

	// The undriven line reads low, as a weak pull-down would make it.
	assign miso_line = miso_oe & miso;

	modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
	modport host (output cs_n, output sclk, output mosi, input miso_line);
endinterface : adc_link_if

// ===== verilog/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// System
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	// Pointers wrap by overflow, so the depth must stay a power of two.
	assign in_ready = cnt_q != CW'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	assign count = cnt_q;
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_valid & out_ready;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

endmodule : sample_fifo

// ===== verilog/adc_device_end.sv
// Notes on behaviour
// R1 - Eight inputs, single-ended or four pairs.
// R2 - Single-ended: selector bits 5:3, legal frame.
// R3 - Differential: 110 on top, 001 below.
// R4 - Selector value picks input of same index.
// R5 - Pair selector picks even/odd inputs, even positive.
// R6 - Three cycles tracking, thirteen hold-convert cycles.
// R7 - Chip select low runs, high shuts down.
// R8 - Output driven after chip select falls.
// R9 - Output released after chip select rises.
// R10 - Output bits launched after clock falling edge.
// R11 - Control bits captured on clock rising edge.
// R12 - Chip select may rise at either level.
// R13 - Result is twelve-bit straight binary.
// R14 - Master keeps rate in 50k-1M samples/s; here frames stop while the result buffer is full.
// R15 - Hold starts at fourth falling edge.
// R16 - Word MSB first; applies to next frame.
// R17 - Leading zeros, then result MSB first.
`timescale 1ns/10ps
module adc_device_end
	import adc_seq_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Serial link
	adc_link_if.dev link,
	// Input levels as codes
	input wire logic [RES_BITS-1:0] analog_in [NUM_INPUTS],
	// Conversion results
	output logic [RES_BITS-1:0] result_q,
	output logic result_valid_q,
	output logic [2:0] result_chan_q,
	output logic result_diff_q,
	// State
	output logic tracking_q,
	output logic shutdown_q,
	output logic [CTRL_BITS-1:0] input_select_control_q
);

	// ----------------------------------------
	// Link edge detection
	// ----------------------------------------
	logic sclk_q;
	logic cs_prev_q;
	logic rise;
	logic fall;
	logic frame_start;
	logic [3:0] rise_cnt_q;
	logic [3:0] fall_cnt_q;

	assign rise = !link.cs_n && link.sclk && !sclk_q;
	assign fall = !link.cs_n && !link.sclk && sclk_q;
	// A frame begins at chip select falling or after sixteen falls.
	assign frame_start = (cs_prev_q && !link.cs_n) || (fall && fall_cnt_q == LAST_EDGE_IDX);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end
		else if (ce)
		begin
			sclk_q <= link.sclk;
			cs_prev_q <= link.cs_n;
		end
	end

	// Counters simply wrap at sixteen, matching back-to-back frames.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rise_cnt_q <= '0;
			fall_cnt_q <= '0;
		end
		else if (ce)
		begin
			if (link.cs_n)
			begin
				rise_cnt_q <= '0;
				fall_cnt_q <= '0;
			end
			else
			begin
				if (rise)
					rise_cnt_q <= rise_cnt_q + 1'b1;
				if (fall)
					fall_cnt_q <= fall_cnt_q + 1'b1; // R6
			end
		end
	end

	// ----------------------------------------
	// Control word capture and decode
	// ----------------------------------------
	logic [CTRL_BITS-2:0] ctrl_shift_q;
	logic [CTRL_BITS-1:0] word;
	logic word_diff;
	logic word_single;
	logic pend_diff_q;
	logic [2:0] pend_sel_q;
	logic act_diff_q;
	logic [2:0] act_sel_q;

	assign word = {ctrl_shift_q, link.mosi};
	assign word_diff = word[TOP_MSB:TOP_LSB] == DIFF_TOP_CODE && word[LOW_MSB:0] == DIFF_LOW_CODE; // R3
	assign word_single = word[TOP_MSB:TOP_LSB+1] != SE_BAD_TOP_CODE && word[LOW_MSB:0] != SE_BAD_LOW_CODE; // R2

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_shift_q <= '0;
			input_select_control_q <= CTRL_RESET;
			pend_diff_q <= 1'b0;
			pend_sel_q <= 3'h0;
		end
		else if (ce && rise && rise_cnt_q <= LAST_CTRL_RISE_IDX)
		begin
			ctrl_shift_q <= word[CTRL_BITS-2:0]; // R11
			if (rise_cnt_q == LAST_CTRL_RISE_IDX)
			begin
				input_select_control_q <= word; // R16
				// An illegal word leaves the previous selection in force.
				if (word_diff)
				begin
					pend_diff_q <= 1'b1;
					pend_sel_q <= {word[PAIR_MSB:PAIR_LSB], 1'b0}; // R5
				end
				else if (word_single)
				begin
					pend_diff_q <= 1'b0;
					pend_sel_q <= word[SEL_MSB:SEL_LSB]; // R4
				end
			end
		end
	end

	// The pending choice takes effect only at a frame boundary.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			act_diff_q <= 1'b0;
			act_sel_q <= 3'h0;
		end
		else if (ce && frame_start)
		begin
			act_diff_q <= pend_diff_q; // R16
			act_sel_q <= pend_sel_q;
		end
	end

	// ----------------------------------------
	// Input multiplexer
	// ----------------------------------------
	logic [RES_BITS-1:0] pair_code [NUM_PAIRS];
	logic [RES_BITS-1:0] sel_code;

	for (genvar p = 0; p < NUM_PAIRS; p++)
	begin : g_pair
		logic signed [RES_BITS:0] diff;
		logic signed [RES_BITS:0] half;
		assign diff = $signed({1'b0, analog_in[2*p]}) - $signed({1'b0, analog_in[2*p+1]});
		assign half = diff >>> 1;
		// Mid-scale offset keeps the difference in straight binary.
		assign pair_code[p] = {~half[RES_BITS-1], half[RES_BITS-2:0]}; // R13
	end

	assign sel_code = act_diff_q ? pair_code[act_sel_q[2:1]] : analog_in[act_sel_q]; // R1

	// ----------------------------------------
	// Track, hold and result
	// ----------------------------------------
	logic hold_now;

	assign hold_now = fall && fall_cnt_q == HOLD_FALL_IDX;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tracking_q <= 1'b0;
		else if (ce)
		begin
			if (link.cs_n)
				tracking_q <= 1'b0;
			else if (frame_start)
				tracking_q <= 1'b1; // R6
			else if (hold_now)
				tracking_q <= 1'b0; // R15
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			result_q <= '0;
			result_valid_q <= 1'b0;
			result_chan_q <= 3'h0;
			result_diff_q <= 1'b0;
		end
		else if (ce)
		begin
			result_valid_q <= hold_now;
			if (hold_now)
			begin
				result_q <= sel_code; // R15
				result_chan_q <= act_sel_q;
				result_diff_q <= act_diff_q;
			end
		end
	end

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	logic [RES_BITS-1:0] out_shift_q;
	logic miso_q;
	logic miso_oe_q;

	assign link.miso = miso_q;
	assign link.miso_oe = miso_oe_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_shift_q <= '0;
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
			shutdown_q <= 1'b1;
		end
		else if (ce)
		begin
			shutdown_q <= link.cs_n; // R7
			// Chip select may rise at any clock level; only its level matters here.
			if (link.cs_n)
			begin
				miso_oe_q <= 1'b0; // R9
				miso_q <= 1'b0; // R12
			end
			else
			begin
				miso_oe_q <= 1'b1; // R8
				if (frame_start)
				begin
					miso_q <= 1'b0; // R17
					out_shift_q <= '0;
				end
				else if (hold_now)
				begin
					miso_q <= sel_code[RES_BITS-1]; // R10
					out_shift_q <= sel_code;
				end
				else if (fall)
				begin
					miso_q <= out_shift_q[RES_BITS-2]; // R17
					out_shift_q <= {out_shift_q[RES_BITS-2:0], 1'b0};
				end
			end
		end
	end

endmodule : adc_device_end

// ===== verilog/adc_host_end.sv
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module adc_host_end
	import adc_seq_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Serial link
	adc_link_if.host link,
	// AXI4-Lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	// ----------------------------------------
	// Result buffer
	// ----------------------------------------
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	logic [FRAME_BITS-1:0] rx_q;
	logic push_valid_q;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic pop_q;
	logic [RES_BITS-1:0] fifo_data;
	logic [CW-1:0] fifo_count;

	sample_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) i_sample_fifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_valid(push_valid_q),
		.in_ready(fifo_in_ready),
		.in_data(rx_q[RES_BITS-1:0]),
		.out_valid(fifo_out_valid),
		.out_ready(pop_q),
		.out_data(fifo_data),
		.count(fifo_count)
	);

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_hold_q, w_hold_q;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_lane0_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic run_q;
	logic [CTRL_BITS-1:0] cmd_q;
	host_state_t state_q;

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_lane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			run_q <= RUN_RESET;
			cmd_q <= CTRL_RESET;
		end
		else if (ce)
		begin
			if (awvalid && awready_q)
			begin
				aw_hold_q <= 1'b1;
				awready_q <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready_q)
			begin
				w_hold_q <= 1'b1;
				wready_q <= 1'b0;
				w_data_q <= wdata;
				w_lane0_q <= wstrb[0];
			end
			if (aw_hold_q && w_hold_q && !bvalid_q)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= RESP_OKAY;
				unique case (aw_addr_q)
					REG_CTRL: if (w_lane0_q) run_q <= w_data_q[CTRL_RUN_BIT];
					REG_CMD: if (w_lane0_q) cmd_q <= w_data_q[CTRL_BITS-1:0]; // R16
					REG_STATUS, REG_DATA: ;
					default: bresp_q <= RESP_SLVERR;
				endcase
			end
			if (bvalid_q && bready)
			begin
				bvalid_q <= 1'b0;
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Reading the data word pops one result; an empty buffer reads zero.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			pop_q <= 1'b0;
		end
		else if (ce)
		begin
			pop_q <= 1'b0;
			if (arvalid && arready_q)
			begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rresp_q <= RESP_OKAY;
				rdata_q <= '0;
				unique case (araddr)
					REG_CTRL: rdata_q[CTRL_RUN_BIT] <= run_q;
					REG_CMD: rdata_q[CTRL_BITS-1:0] <= cmd_q;
					REG_STATUS:
					begin
						rdata_q[CW-1:0] <= fifo_count;
						rdata_q[STAT_EMPTY_BIT] <= !fifo_out_valid;
						rdata_q[STAT_FULL_BIT] <= !fifo_in_ready;
						rdata_q[STAT_BUSY_BIT] <= state_q != S_IDLE;
					end
					REG_DATA:
					begin
						rdata_q[RES_BITS-1:0] <= fifo_out_valid ? fifo_data : '0;
						pop_q <= fifo_out_valid;
					end
					default: rresp_q <= RESP_SLVERR;
				endcase
			end
			if (rvalid_q && rready)
			begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	logic cs_n_q, sclk_q, mosi_q;
	logic [CTRL_BITS-1:0] word_q;
	logic [3:0] div_q, edge_cnt_q, gap_q;

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.mosi = mosi_q;

	// A full buffer holds the finished frame back, so the frame rate drops while software lags.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= S_IDLE;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			word_q <= '0;
			div_q <= '0;
			edge_cnt_q <= '0;
			gap_q <= '0;
			rx_q <= '0;
			push_valid_q <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state_q)
				S_IDLE:
					if (run_q)
					begin
						cs_n_q <= 1'b0;
						word_q <= cmd_q;
						mosi_q <= cmd_q[CTRL_BITS-1]; // R11
						div_q <= '0;
						edge_cnt_q <= '0;
						state_q <= S_SHIFT;
					end
				S_SHIFT:
					if (div_q == 4'(SCLK_HALF_CYCLES - 1))
					begin
						div_q <= '0;
						sclk_q <= !sclk_q;
						if (!sclk_q)
							rx_q <= {rx_q[FRAME_BITS-2:0], link.miso_line}; // R10
						else
						begin
							edge_cnt_q <= edge_cnt_q + 1'b1;
							word_q <= {word_q[CTRL_BITS-2:0], 1'b0};
							mosi_q <= word_q[CTRL_BITS-2]; // R16
							if (edge_cnt_q == LAST_EDGE_IDX)
							begin
								cs_n_q <= 1'b1; // R12
								push_valid_q <= 1'b1;
								state_q <= S_PUSH;
							end
						end
					end
					else
						div_q <= div_q + 1'b1;
				S_PUSH:
					if (fifo_in_ready)
					begin
						push_valid_q <= 1'b0;
						gap_q <= '0;
						state_q <= S_GAP;
					end
				S_GAP:
					if (gap_q == 4'(CS_GAP_CYCLES - 1))
						state_q <= S_IDLE; // R14
					else
						gap_q <= gap_q + 1'b1;
			endcase
		end
	end

endmodule : adc_host_end

// ===== verif/adc_link_monitor.sv
`timescale 1ns/10ps
module adc_link_monitor
	import adc_seq_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rst,
	// Serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic miso_line
);
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Frame bookkeeping
	// ----------------------------------------
	logic sclk_q;
	logic rise_seen;
	logic [4:0] rise_cnt_q;

	assign rise_seen = sclk & ~sclk_q;

	always_ff @(posedge clk or posedge rst)
		if (rst)
			sclk_q <= 1'b0;
		else
			sclk_q <= sclk;

	// The count restarts while select is high, so a frame cut short shows as a wrong total.
	always_ff @(posedge clk or posedge rst)
		if (rst)
			rise_cnt_q <= 5'h00;
		else if (cs_n)
			rise_cnt_q <= 5'h00;
		else if (rise_seen)
			rise_cnt_q <= rise_cnt_q + 5'h01;

	sequence sclk_lead;
		!sclk ##1 !sclk ##1 sclk;
	endsequence

	sequence sclk_high;
		sclk[*2] ##1 !sclk;
	endsequence

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	oe_enable_a: assert property ($fell(cs_n) |-> ##[1:3] miso_oe)
		else $error("output not driven after select fell");
	oe_release_a: assert property ($rose(cs_n) |-> ##[1:3] !miso_oe)
		else $error("output not released after select rose");
	shutdown_quiet_a: assert property (cs_n[*4] |-> !miso_oe)
		else $error("output driven while shut down");
	miso_launch_a: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk)
		else $error("output bit changed while clock high");
	mosi_capture_a: assert property (sclk |-> $stable(mosi))
		else $error("control bit changed while clock high");
	lead_zero_a: assert property (rise_seen && rise_cnt_q < 5'h04 |-> !miso_line)
		else $error("leading bit not zero");
	word_tail_a: assert property (rise_seen && rise_cnt_q >= 5'h08 |-> !mosi)
		else $error("control line not zero after the word");
	frame_count_a: assert property ($rose(cs_n) |-> rise_cnt_q == 5'h10)
		else $error("frame did not hold sixteen clocks");
	frame_start_a: assert property ($fell(cs_n) |-> sclk_lead)
		else $error("clock not low at frame start");
	idle_clock_a: assert property (cs_n |-> !sclk)
		else $error("clock moved outside a frame");
	sclk_phase_a: assert property ($rose(sclk) |-> sclk_high)
		else $error("clock high phase wrong");
endmodule : adc_link_monitor

// ===== verif/tb_adc_serial_channel_sequencer.sv
`timescale 1ns/10ps
module tb_adc_serial_channel_sequencer
	import adc_seq_pkg::*;
;
	logic clk;
	logic rst;
	logic [3:0] awaddr, araddr, wstrb;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [RES_BITS-1:0] levels [NUM_INPUTS];
	logic [RES_BITS-1:0] res;
	logic res_diff, shutdown, trk, res_valid, ce;
	int pulses = 0;
	logic [2:0] res_chan;
	logic [CTRL_BITS-1:0] sel_word;
	int fail_count = 0;
	int tests_run = 0;
	int wd = 0;

	adc_link_if link ();

	adc_device_end i_adc_device_end (.clk(clk), .rst(rst), .ce(ce), .link(link.dev), .analog_in(levels),
		.result_q(res), .result_valid_q(res_valid), .result_chan_q(res_chan), .result_diff_q(res_diff),
		.tracking_q(trk), .shutdown_q(shutdown), .input_select_control_q(sel_word));

	adc_host_end i_adc_host_end (.clk(clk), .rst(rst), .ce(ce), .link(link.host), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	adc_link_monitor i_adc_link_monitor (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
		.mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .miso_line(link.miso_line));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		logic [1:0] r;
		axi_rd(a, d, r);
	endtask : rd

	function automatic logic [11:0] code_of(input int sel, input logic df);
		if (df)
			return 12'(2048 + ((int'(levels[2 * sel]) - int'(levels[2 * sel + 1])) >>> 1));
		return levels[sel];
	endfunction : code_of

	// ----------------------------------------
	// One selection: fill the buffer, stall, drain
	// ----------------------------------------
	task automatic run_word(input logic [7:0] w, input logic [11:0] e_new, input logic [11:0] e_old,
		input logic [2:0] ch, input logic df);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		axi_wr(REG_CMD, {24'h0, w}, 4'hf, r);
		axi_wr(REG_CTRL, 32'h1, 4'hf, r);
		wait (link.cs_n === 1'b0);
		repeat (5) @(posedge clk);
		chk({31'h0, shutdown}, 32'h0, "shutdown in frame");
		chk({31'h0, link.miso_oe}, 32'h1, "output driven");
		chk({31'h0, trk}, 32'h1, "tracking");
		// Both ends freeze in a low clock phase, so the link stays legal while stalled.
		ce <= 1'b0;
		repeat (22) @(posedge clk);
		chk({31'h0, link.sclk}, 32'h0, "clock frozen");
		ce <= 1'b1;
		d = 32'h0;
		while (d[STAT_FULL_BIT] !== 1'b1)
			rd(REG_STATUS, d);
		repeat (300) @(posedge clk);
		rd(REG_STATUS, d);
		chk({25'h0, d[6:0]}, 32'h68, "full stall");
		axi_wr(REG_CTRL, 32'h0, 4'hf, r);
		n = 0;
		rd(REG_STATUS, d);
		// A word takes effect one frame late, so the first entry still carries the old selection.
		while (d[STAT_EMPTY_BIT] !== 1'b1)
		begin
			rd(REG_DATA, d);
			chk(d, {20'h0, n == 0 ? e_old : e_new}, "result");
			n++;
			rd(REG_STATUS, d);
		end
		chk(32'(n), 32'(FIFO_DEPTH + 1), "drained count");
		chk({31'h0, shutdown}, 32'h1, "shutdown idle");
		chk({31'h0, trk}, 32'h0, "tracking idle");
		chk({31'h0, link.miso_oe}, 32'h0, "output released");
		chk({24'h0, sel_word}, {24'h0, w}, "word held");
		chk({28'h0, res_diff, res_chan}, {28'h0, df, ch}, "selection");
		chk({20'h0, res}, {20'h0, e_new}, "last code");
		$display("test word %h done", w);
	endtask : run_word

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [11:0] prev;
		logic [7:0] w;
		int sel;
		logic df;
		rst = 1'b1;
		ce = 1'b1;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		for (int i = 0; i < NUM_INPUTS; i++)
			levels[i] = 12'h123 + 12'(i) * 12'h1d9;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		chk({24'h0, sel_word}, {24'h0, CTRL_RESET}, "word reset");
		chk({31'h0, link.miso_oe}, 32'h0, "output idle");
		for (int i = 0; i < 4; i++)
		begin
			rd(4'(4 * i), d);
			chk(d, i == 2 ? 32'h10 : 32'h0, "register reset");
		end
		axi_rd(4'h2, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
		axi_wr(4'h2, 32'hffff_ffff, 4'hf, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
		axi_wr(REG_CMD, 32'h0000_00b5, 4'he, r);
		rd(REG_CMD, d);
		chk(d, 32'h0, "masked write");
		$display("test registers done");
		prev = levels[0];
		sel = 0;
		df = 1'b0;
		for (int k = 0; k < 14; k++)
		begin
			if (k < 8)
			begin
				w = {2'b00, 3'(k), 3'b000};
				sel = k;
			end
			else if (k < 12)
			begin
				w = {3'b110, 2'(k - 8), 3'b001};
				sel = k - 8;
				df = 1'b1;
			end
			else
				w = (k == 12) ? 8'hf8 : 8'h29;
			run_word(w, code_of(sel, df), prev, df ? 3'(2 * sel) : 3'(sel), df);
			prev = code_of(sel, df);
		end
		chk(32'(pulses), 32'(14 * (FIFO_DEPTH + 1)), "result pulses");
		final_report();
	end

	always @(posedge clk)
	begin
		wd <= wd + 1;
		if (res_valid === 1'b1)
			pulses <= pulses + 1;
		if (wd == 60000)
		begin
			fail_count++;
			final_report();
		end
	end
endmodule : tb_adc_serial_channel_sequencer
